// ===== hdl/pfsr_pkg.sv
// constants and types for the pin function select and read-back block
package pfsr_pkg;
	// ***************************************
	// sizes
	// ***************************************
	localparam int NPIN = 24;
	localparam int NPA  = 8;
	localparam int NSEL = 7;
	localparam int NPRT = 4;
	// ***************************************
	// register word indices (byte address = 4 * index)
	// ***************************************
	localparam logic [4:0] IDX_SEL0    = 5'h00;
	localparam logic [4:0] IDX_UNLOCK  = 5'h07;
	localparam logic [4:0] IDX_STATUS  = 5'h08;
	localparam logic [4:0] IDX_DATA0   = 5'h09;
	localparam logic [4:0] IDX_DIR0    = 5'h0D;
	localparam logic [4:0] IDX_BITOP   = 5'h11;
	localparam logic [4:0] IDX_WAKEEN  = 5'h12;
	localparam logic [4:0] IDX_PA      = 5'h13;
	// ***************************************
	// field layouts and values
	// ***************************************
	localparam logic [7:0] SEL_MASK_D  = 8'h3F;
	localparam logic [7:0] SEL_MASK_G1 = 8'h03;
	localparam logic [7:0] SEL_MASK    = 8'hFF;
	localparam logic [7:0] SEL_RST     = 8'h00;
	localparam logic [7:0] UNLOCK_RST  = 8'h00;
	localparam logic [7:0] UNLOCK_KEY  = 8'hCA;
	localparam logic [7:0] PORT_RST    = 8'hFF;
	localparam logic [7:0] WAKE_RST    = 8'h00;
	localparam logic [7:0] MASK_D      = 8'h70;
	localparam logic [7:0] MASK_E      = 8'hFF;
	localparam logic [7:0] MASK_F      = 8'hFF;
	localparam logic [7:0] MASK_G      = 8'h1F;
	localparam int BOP_VAL  = 0;
	localparam int BOP_BITL = 1;
	localparam int BOP_PRTL = 4;
	localparam int BOP_DIR  = 6;
	// pin positions in the flat pin vector
	localparam int PIN_D4 = 0;
	localparam int PIN_D5 = 1;
	localparam int PIN_D6 = 2;
	localparam int PIN_G0 = 19;
	localparam int PIN_G2 = 21;
	localparam int PIN_G3 = 22;
	localparam int PIN_G4 = 23;
	// selection codes, bus responses and the zero read word
	localparam logic [1:0] CODE_00 = 2'h0;
	localparam logic [1:0] CODE_01 = 2'h1;
	localparam logic [1:0] CODE_10 = 2'h2;
	localparam logic [1:0] CODE_11 = 2'h3;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] RD_ZERO    = 32'h0000_0000;
	// ***************************************
	// pin function classes
	// ***************************************
	typedef enum logic [1:0] {
		CLS_GPIO   = 2'h0,
		CLS_DOUT   = 2'h1,
		CLS_SERIAL = 2'h3,
		CLS_ANALOG = 2'h2
	} pfsr_cls_t;
endpackage

// ===== hdl/pfsr_top.sv
// pin function multiplexer with read-back unlock, ports D upper, E, F, G
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pfsr_top (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RESET,
	// axi4-lite write
	input  wire logic        AWVALID,
	output logic             AWREADY,
	input  wire logic [31:0] AWADDR,
	input  wire logic        WVALID,
	output logic             WREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	output logic             BVALID,
	input  wire logic        BREADY,
	output logic [1:0]       BRESP,
	// axi4-lite read
	input  wire logic        ARVALID,
	output logic             ARREADY,
	input  wire logic [31:0] ARADDR,
	output logic             RVALID,
	input  wire logic        RREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	// shared pins: d4-d6, e0-e7, f0-f7, g0-g4
	input  wire logic [23:0] PIN_IN,
	output logic      [23:0] PIN_OUT,
	output logic      [23:0] PIN_OE,
	output logic      [23:0] ANALOG_EN,
	// peripheral sources
	input  wire logic        SDO_OUT,
	input  wire logic        SDA_OUT,
	input  wire logic        SDA_OE,
	input  wire logic        UART_ZERO_TX_OUT,
	input  wire logic        UART_ZERO_TX_OE,
	input  wire logic        PERIODIC_TIMER0_INVERTED_OUT,
	input  wire logic        AUDIO_TIMER_OUTPUT_FIRST_PWM,
	input  wire logic        AUDIO_TIMER_INVERTED_SECOND_PWM,
	// peripheral inputs from pins
	output logic             EXTERNAL_INTERRUPT_FOUR,
	output logic             SDI_IN,
	output logic             UART_ZERO_RX_IN,
	// port a wake-up and status
	input  wire logic [7:0]  PORTA_IN,
	input  wire logic        SLEEP,
	output logic             WAKE,
	output logic             READBACK_ENABLED_FLAG
);
	// ***************************************
	// storage
	// ***************************************
	logic [7:0]  sel_r [pfsr_pkg::NSEL];
	logic [7:0]  sel_nxt [pfsr_pkg::NSEL];
	logic [7:0]  data_r [pfsr_pkg::NPRT];
	logic [7:0]  dir_r [pfsr_pkg::NPRT];
	logic [7:0]  port_rd [pfsr_pkg::NPRT];
	logic [7:0]  readback_unlock_byte_r;
	logic [7:0]  unlock_nxt;
	logic [7:0]  wake_en_r;
	logic        rb_en_r;
	logic [23:0] pin_s1_r;
	logic [23:0] pin_s2_r;
	logic [7:0]  pa_s1_r;
	logic [7:0]  pa_s2_r;
	logic [7:0]  pa_prev_r;
	logic        aw_held_r;
	logic        w_held_r;
	logic [4:0]  aw_idx_r;
	logic [31:0] wdata_r;
	logic        wstrb0_r;
	logic        wr_fire;
	logic        wr_ok;
	logic        wr_map;
	logic [47:0] selv;
	logic [47:0] selv_nxt;
	logic [23:0] flat_data;
	logic [23:0] flat_dir;
	logic [23:0] rd_flat;
	logic [23:0] per_out;
	logic [23:0] per_oe;
	logic [23:0] out_nxt;
	logic [23:0] oe_nxt;
	logic [23:0] ana_nxt;
	logic [7:0]  rd_mux;
	logic        rd_map;
	logic [4:0]  ar_idx;
	logic [1:0]  bop_prt;
	logic [2:0]  bop_bit;
	logic [7:0]  bop_new;
	logic [7:0]  prt_mask [pfsr_pkg::NPRT];

	assign prt_mask[0] = pfsr_pkg::MASK_D;
	assign prt_mask[1] = pfsr_pkg::MASK_E;
	assign prt_mask[2] = pfsr_pkg::MASK_F;
	assign prt_mask[3] = pfsr_pkg::MASK_G;

	// ***************************************
	// function class of a pin for a code
	// ***************************************
	function automatic pfsr_pkg::pfsr_cls_t pin_cls(input int p,
		input logic [1:0] c);
		pfsr_pkg::pfsr_cls_t k;
		k = pfsr_pkg::CLS_GPIO;
		if (p == pfsr_pkg::PIN_D4) begin
			case (c)
				pfsr_pkg::CODE_01: k = pfsr_pkg::CLS_DOUT;
				pfsr_pkg::CODE_10: k = pfsr_pkg::CLS_SERIAL;
				pfsr_pkg::CODE_11: k = pfsr_pkg::CLS_ANALOG;
				default: k = pfsr_pkg::CLS_GPIO;
			endcase
		end else if (p == pfsr_pkg::PIN_D5) begin
			case (c)
				pfsr_pkg::CODE_01: k = pfsr_pkg::CLS_SERIAL;
				pfsr_pkg::CODE_10: k = pfsr_pkg::CLS_SERIAL;
				pfsr_pkg::CODE_11: k = pfsr_pkg::CLS_ANALOG;
				default: k = pfsr_pkg::CLS_GPIO;
			endcase
		end else if (p == pfsr_pkg::PIN_D6) begin
			case (c)
				pfsr_pkg::CODE_01: k = pfsr_pkg::CLS_DOUT;
				pfsr_pkg::CODE_11: k = pfsr_pkg::CLS_ANALOG;
				default: k = pfsr_pkg::CLS_GPIO;
			endcase
		end else if (p == pfsr_pkg::PIN_G3 || p == pfsr_pkg::PIN_G4) begin
			if (c == pfsr_pkg::CODE_01)
				k = pfsr_pkg::CLS_DOUT;
		end else if (c == pfsr_pkg::CODE_11) begin
			k = pfsr_pkg::CLS_ANALOG;
		end
		return k;
	endfunction

	// ***************************************
	// pin synchronisers and port a edge
	// ***************************************
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			pin_s1_r  <= 24'h00_0000;
			pin_s2_r  <= 24'h00_0000;
			pa_s1_r   <= 8'hFF;
			pa_s2_r   <= 8'hFF;
			pa_prev_r <= 8'hFF;
		end else begin
			pin_s1_r  <= PIN_IN;
			pin_s2_r  <= pin_s1_r;
			pa_s1_r   <= PORTA_IN;
			pa_s2_r   <= pa_s1_r;
			pa_prev_r <= pa_s2_r;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET)
			WAKE <= 1'b0;
		else
			WAKE <= SLEEP & |(wake_en_r & pa_prev_r & ~pa_s2_r);
	end

	// ***************************************
	// axi4-lite write channel
	// ***************************************
	assign wr_fire = aw_held_r & w_held_r & ~BVALID;
	assign wr_map  = aw_idx_r <= pfsr_pkg::IDX_PA;
	assign wr_ok   = wr_fire & wr_map & wstrb0_r;

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			aw_idx_r  <= 5'h00;
			wdata_r   <= 32'h0000_0000;
			wstrb0_r  <= 1'b0;
			AWREADY   <= 1'b0;
			WREADY    <= 1'b0;
			BVALID    <= 1'b0;
			BRESP     <= pfsr_pkg::RESP_OKAY;
		end else begin
			AWREADY <= ~aw_held_r & ~(AWVALID & AWREADY) & ~BVALID;
			WREADY  <= ~w_held_r & ~(WVALID & WREADY) & ~BVALID;
			if (AWVALID & AWREADY) begin
				aw_held_r <= 1'b1;
				aw_idx_r  <= AWADDR[6:2];
				if (AWADDR[31:7] != 25'h000_0000)
					aw_idx_r <= 5'h1F;
			end
			if (WVALID & WREADY) begin
				w_held_r <= 1'b1;
				wdata_r  <= WDATA;
				wstrb0_r <= WSTRB[0];
			end
			if (wr_fire) begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				BVALID    <= 1'b1;
				BRESP     <= wr_map ? pfsr_pkg::RESP_OKAY
				                    : pfsr_pkg::RESP_SLVERR;
			end else if (BVALID & BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	// ***************************************
	// selection, unlock and wake enable registers
	// ***************************************
	always_comb begin
		for (int i = 0; i < pfsr_pkg::NSEL; i++) begin
			sel_nxt[i] = sel_r[i];
			if (wr_ok && aw_idx_r == pfsr_pkg::IDX_SEL0 + 5'(i))
				sel_nxt[i] = wdata_r[7:0];
		end
		sel_nxt[0] = sel_nxt[0] & pfsr_pkg::SEL_MASK_D;
		sel_nxt[6] = sel_nxt[6] & pfsr_pkg::SEL_MASK_G1;
		unlock_nxt = readback_unlock_byte_r;
		if (wr_ok && aw_idx_r == pfsr_pkg::IDX_UNLOCK)
			unlock_nxt = wdata_r[7:0];
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			for (int i = 0; i < pfsr_pkg::NSEL; i++)
				sel_r[i] <= pfsr_pkg::SEL_RST;
			readback_unlock_byte_r <= pfsr_pkg::UNLOCK_RST;
			rb_en_r                <= 1'b0;
			READBACK_ENABLED_FLAG  <= 1'b0;
			wake_en_r              <= pfsr_pkg::WAKE_RST;
		end else begin
			for (int i = 0; i < pfsr_pkg::NSEL; i++)
				sel_r[i] <= sel_nxt[i];
			readback_unlock_byte_r <= unlock_nxt;
			rb_en_r <= unlock_nxt == pfsr_pkg::UNLOCK_KEY;
			READBACK_ENABLED_FLAG <= unlock_nxt == pfsr_pkg::UNLOCK_KEY;
			if (wr_ok && aw_idx_r == pfsr_pkg::IDX_WAKEEN)
				wake_en_r <= wdata_r[7:0];
		end
	end

	assign selv = {sel_r[6][1:0], sel_r[5], sel_r[4], sel_r[3],
		sel_r[2], sel_r[1], sel_r[0][5:0]};
	assign selv_nxt = {sel_nxt[6][1:0], sel_nxt[5], sel_nxt[4],
		sel_nxt[3], sel_nxt[2], sel_nxt[1], sel_nxt[0][5:0]};
	assign flat_data = {data_r[3][4:0], data_r[2], data_r[1],
		data_r[0][6:4]};
	assign flat_dir = {dir_r[3][4:0], dir_r[2], dir_r[1], dir_r[0][6:4]};

	// ***************************************
	// port read value
	// ***************************************
	always_comb begin
		for (int p = 0; p < pfsr_pkg::NPIN; p++) begin
			if (rb_en_r) begin
				rd_flat[p] = pin_s2_r[p];
			end else begin
				case (pin_cls(p, selv[2*p +: 2]))
					pfsr_pkg::CLS_GPIO:   rd_flat[p] = pin_s2_r[p];
					pfsr_pkg::CLS_DOUT:   rd_flat[p] = ~flat_dir[p] & flat_data[p];
					pfsr_pkg::CLS_SERIAL: rd_flat[p] = flat_dir[p] ? pin_s2_r[p]
					                                              : flat_data[p];
					default:              rd_flat[p] = 1'b0;
				endcase
			end
		end
		port_rd[0] = {1'b0, rd_flat[2:0], 4'h0};
		port_rd[1] = rd_flat[10:3];
		port_rd[2] = rd_flat[18:11];
		port_rd[3] = {3'h0, rd_flat[23:19]};
	end

	// ***************************************
	// data and direction registers, bit operations
	// ***************************************
	assign bop_prt = wdata_r[pfsr_pkg::BOP_PRTL +: 2];
	assign bop_bit = wdata_r[pfsr_pkg::BOP_BITL +: 3];

	always_comb begin
		bop_new = (port_rd[bop_prt] & prt_mask[bop_prt])
			| (data_r[bop_prt] & ~prt_mask[bop_prt]);
		bop_new[bop_bit] = wdata_r[pfsr_pkg::BOP_VAL];
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			for (int i = 0; i < pfsr_pkg::NPRT; i++) begin
				data_r[i] <= pfsr_pkg::PORT_RST;
				dir_r[i]  <= pfsr_pkg::PORT_RST;
			end
		end else if (wr_ok) begin
			for (int i = 0; i < pfsr_pkg::NPRT; i++) begin
				if (aw_idx_r == pfsr_pkg::IDX_DATA0 + 5'(i))
					data_r[i] <= wdata_r[7:0];
				if (aw_idx_r == pfsr_pkg::IDX_DIR0 + 5'(i))
					dir_r[i] <= wdata_r[7:0];
			end
			if (aw_idx_r == pfsr_pkg::IDX_BITOP) begin
				if (wdata_r[pfsr_pkg::BOP_DIR])
					dir_r[bop_prt][bop_bit] <= wdata_r[pfsr_pkg::BOP_VAL];
				else
					data_r[bop_prt] <= bop_new;
			end
		end
	end

	// ***************************************
	// pin routing
	// ***************************************
	always_comb begin
		per_out = 24'h00_0000;
		per_oe  = 24'h00_0000;
		per_out[pfsr_pkg::PIN_D4] = (selv_nxt[1:0] == pfsr_pkg::CODE_01)
			? SDO_OUT : UART_ZERO_TX_OUT;
		per_oe[pfsr_pkg::PIN_D4]  = 1'b1;
		per_out[pfsr_pkg::PIN_D5] = (selv_nxt[3:2] == pfsr_pkg::CODE_01)
			? SDA_OUT : UART_ZERO_TX_OUT;
		per_oe[pfsr_pkg::PIN_D5]  = (selv_nxt[3:2] == pfsr_pkg::CODE_01)
			? SDA_OE : UART_ZERO_TX_OE;
		per_out[pfsr_pkg::PIN_D6] = PERIODIC_TIMER0_INVERTED_OUT;
		per_out[pfsr_pkg::PIN_G3] = AUDIO_TIMER_OUTPUT_FIRST_PWM;
		per_out[pfsr_pkg::PIN_G4] = AUDIO_TIMER_INVERTED_SECOND_PWM;
		for (int p = 0; p < pfsr_pkg::NPIN; p++) begin
			ana_nxt[p] = 1'b0;
			case (pin_cls(p, selv_nxt[2*p +: 2]))
				pfsr_pkg::CLS_GPIO: begin
					out_nxt[p] = flat_data[p];
					oe_nxt[p]  = ~flat_dir[p];
				end
				pfsr_pkg::CLS_DOUT: begin
					out_nxt[p] = per_out[p];
					oe_nxt[p]  = 1'b1;
				end
				pfsr_pkg::CLS_SERIAL: begin
					out_nxt[p] = per_out[p];
					oe_nxt[p]  = per_oe[p];
				end
				default: begin
					out_nxt[p] = 1'b0;
					oe_nxt[p]  = 1'b0;
					ana_nxt[p] = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			PIN_OUT   <= 24'h00_0000;
			PIN_OE    <= 24'h00_0000;
			ANALOG_EN <= 24'h00_0000;
			EXTERNAL_INTERRUPT_FOUR <= 1'b0;
			SDI_IN          <= 1'b1;
			UART_ZERO_RX_IN <= 1'b1;
		end else begin
			PIN_OUT   <= out_nxt;
			PIN_OE    <= oe_nxt;
			ANALOG_EN <= ana_nxt;
			EXTERNAL_INTERRUPT_FOUR <= (pin_cls(pfsr_pkg::PIN_D6,
				selv[5:4]) == pfsr_pkg::CLS_GPIO) & pin_s2_r[pfsr_pkg::PIN_D6];
			SDI_IN <= (selv[3:2] == pfsr_pkg::CODE_01)
				? pin_s2_r[pfsr_pkg::PIN_D5] : 1'b1;
			UART_ZERO_RX_IN <= (selv[3:2] == pfsr_pkg::CODE_10)
				? pin_s2_r[pfsr_pkg::PIN_D5] : 1'b1;
		end
	end

	// ***************************************
	// axi4-lite read channel
	// ***************************************
	assign ar_idx = ARADDR[6:2];

	always_comb begin
		rd_mux = 8'h00;
		rd_map = ARADDR[31:7] == 25'h000_0000;
		if (ar_idx < pfsr_pkg::IDX_UNLOCK)
			rd_mux = sel_r[3'(ar_idx)];
		else if (ar_idx == pfsr_pkg::IDX_UNLOCK)
			rd_mux = readback_unlock_byte_r;
		else if (ar_idx == pfsr_pkg::IDX_STATUS)
			rd_mux = {7'h00, rb_en_r};
		else if (ar_idx < pfsr_pkg::IDX_DIR0)
			rd_mux = port_rd[2'(ar_idx - pfsr_pkg::IDX_DATA0)];
		else if (ar_idx < pfsr_pkg::IDX_BITOP)
			rd_mux = dir_r[2'(ar_idx - pfsr_pkg::IDX_DIR0)];
		else if (ar_idx == pfsr_pkg::IDX_WAKEEN)
			rd_mux = wake_en_r;
		else if (ar_idx == pfsr_pkg::IDX_PA)
			rd_mux = pa_s2_r;
		else if (ar_idx != pfsr_pkg::IDX_BITOP)
			rd_map = 1'b0;
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b0;
			RDATA   <= pfsr_pkg::RD_ZERO;
			RRESP   <= pfsr_pkg::RESP_OKAY;
		end else begin
			ARREADY <= ~RVALID & ~(ARVALID & ARREADY);
			if (ARVALID & ARREADY) begin
				RVALID <= 1'b1;
				RDATA  <= rd_map ? {24'h00_0000, rd_mux} : pfsr_pkg::RD_ZERO;
				RRESP  <= rd_map ? pfsr_pkg::RESP_OKAY : pfsr_pkg::RESP_SLVERR;
			end else if (RVALID & RREADY) begin
				RVALID <= 1'b0;
			end
		end
	end
endmodule // pfsr_top
`default_nettype wire

// ===== tb/pfsr_pin_model.sv
// model of the board wiring around the shared pins
`timescale 1ns/1ps
`default_nettype none
module pfsr_pin_model (
	// drive from the block
	input  wire logic [23:0] pin_out,
	input  wire logic [23:0] pin_oe,
	// outside drivers
	input  wire logic [23:0] ext_en,
	input  wire logic [23:0] ext_val,
	// resolved pin levels
	output logic      [23:0] pin_lvl
);
	// block drive wins, then an outside driver, else the pull-up
	assign pin_lvl = (pin_oe & pin_out)
		| (~pin_oe & ((ext_en & ext_val) | ~ext_en));
endmodule // pfsr_pin_model
`default_nettype wire

// ===== tb/pfsr_properties.sv
// port assertions for the pin function select block
`timescale 1ns/1ps
`default_nettype none
module pfsr_properties (
	// clock and reset
	input wire logic        CLK,
	input wire logic        RESET,
	// register bus
	input wire logic        AWVALID,
	input wire logic        AWREADY,
	input wire logic [31:0] AWADDR,
	input wire logic        WVALID,
	input wire logic        WREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0]  WSTRB,
	input wire logic        BVALID,
	input wire logic [1:0]  BRESP,
	input wire logic        ARVALID,
	input wire logic        ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic        RVALID,
	// pins and peripherals
	input wire logic [23:0] PIN_OUT,
	input wire logic [23:0] PIN_OE,
	input wire logic [23:0] ANALOG_EN,
	input wire logic        UART_ZERO_TX_OUT,
	input wire logic        PERIODIC_TIMER0_INVERTED_OUT,
	input wire logic [7:0]  PORTA_IN,
	input wire logic        WAKE,
	input wire logic        READBACK_ENABLED_FLAG
);
	logic [7:0] aw_r;
	logic [7:0] wd_r;
	logic [7:0] unl_r;
	logic [5:0] seld_r;
	logic       ws_r;
	logic       bv_r;
	logic [7:0] unl_now;
	// unlock value as the design holds it from the write edge on
	assign unl_now = (BVALID && !bv_r && ws_r && aw_r == 8'h1C
		&& BRESP == pfsr_pkg::RESP_OKAY) ? wd_r : unl_r;
	// shadow of the port d select and unlock registers
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			{aw_r, wd_r, unl_r, seld_r, ws_r, bv_r} <= '0;
		end else begin
			bv_r <= BVALID;
			if (AWVALID && AWREADY) aw_r <= AWADDR[7:0];
			if (WVALID && WREADY) wd_r <= WDATA[7:0];
			if (WVALID && WREADY) ws_r <= WSTRB[0];
			if (BVALID && !bv_r && ws_r && BRESP == pfsr_pkg::RESP_OKAY) begin
				if (aw_r == 8'h00) seld_r <= wd_r[5:0];
				if (aw_r == 8'h1C) unl_r <= wd_r;
			end
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	AST_FLAG_KEY: assert property (
		READBACK_ENABLED_FLAG == (unl_now == pfsr_pkg::UNLOCK_KEY))
		else $error("read-back flag differs from unlock key");
	AST_PD6_TIMER: assert property (
		seld_r[5:4] == pfsr_pkg::CODE_01 && !BVALID |-> PIN_OE[2]
		&& PIN_OUT[2] == $past(PERIODIC_TIMER0_INVERTED_OUT))
		else $error("pd6 does not carry the timer output");
	AST_PD4_TX: assert property (
		seld_r[1:0] == pfsr_pkg::CODE_10 && !BVALID |-> PIN_OE[0]
		&& PIN_OUT[0] == $past(UART_ZERO_TX_OUT))
		else $error("pd4 does not carry the uart transmit");
	AST_PD4_SEG: assert property (
		seld_r[1:0] == pfsr_pkg::CODE_11 && !BVALID |-> ANALOG_EN[0]
		&& !PIN_OE[0]) else $error("pd4 segment not analog");
	AST_ANALOG_NO_DRIVE: assert property (
		(ANALOG_EN & PIN_OE) == 24'h00_0000)
		else $error("analog pin is driven");
	AST_WR_ANSWER: assert property (
		AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
		else $error("write response late");
	AST_RD_ANSWER: assert property (
		ARVALID && ARREADY |=> RVALID && RDATA[31:8] == 24'h00_0000)
		else $error("read answer late or upper bits set");
	AST_WAKE_CAUSE: assert property (
		WAKE |-> (($past(PORTA_IN, 5) & ~$past(PORTA_IN, 4))
		| ($past(PORTA_IN, 4) & ~$past(PORTA_IN, 3))
		| ($past(PORTA_IN, 3) & ~$past(PORTA_IN, 2))) != 8'h00)
		else $error("wake without a falling edge");
	COV_FLAG: cover property (READBACK_ENABLED_FLAG);
	COV_WAKE: cover property (WAKE);
	COV_TX: cover property (seld_r[1:0] == pfsr_pkg::CODE_10 && !BVALID);
endmodule // pfsr_properties
bind pfsr_top pfsr_properties i_props (.CLK(CLK), .RESET(RESET),
	.AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
	.WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
	.BVALID(BVALID), .BRESP(BRESP), .ARVALID(ARVALID),
	.ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID),
	.PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .ANALOG_EN(ANALOG_EN),
	.UART_ZERO_TX_OUT(UART_ZERO_TX_OUT),
	.PERIODIC_TIMER0_INVERTED_OUT(PERIODIC_TIMER0_INVERTED_OUT),
	.PORTA_IN(PORTA_IN), .WAKE(WAKE),
	.READBACK_ENABLED_FLAG(READBACK_ENABLED_FLAG));
`default_nettype wire

// ===== tb/tb_pin_function_select_readback.sv
// self-checking bench for the pin function select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
	$display("ERROR %s expected %h seen %h", n, e, s); end end
module tb_pin_function_select_readback;
	logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, tx, txoe, pt0;
	logic        external_interrupt_four, sdi, rxi, sleep, wake, flag, atp, atpb;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rs;
	logic [23:0] pin_in, pin_out, pin_oe, analog_en, ext_en, ext_val, an_b;
	logic [7:0]  porta, rd;
	int          failures, checks;
	pfsr_top i_dut (.CLK(clk), .RESET(rst), .AWVALID(awvalid),
		.AWREADY(awready), .AWADDR(awaddr), .WVALID(wvalid),
		.WREADY(wready), .WDATA(wdata), .WSTRB(wstrb), .BVALID(bvalid),
		.BREADY(bready), .BRESP(bresp), .ARVALID(arvalid),
		.ARREADY(arready), .ARADDR(araddr), .RVALID(rvalid),
		.RREADY(rready), .RDATA(rdata), .RRESP(rresp), .PIN_IN(pin_in),
		.PIN_OUT(pin_out), .PIN_OE(pin_oe), .ANALOG_EN(analog_en),
		.SDO_OUT(1'b0), .SDA_OUT(1'b0), .SDA_OE(1'b0),
		.UART_ZERO_TX_OUT(tx), .UART_ZERO_TX_OE(txoe),
		.PERIODIC_TIMER0_INVERTED_OUT(pt0),
		.AUDIO_TIMER_OUTPUT_FIRST_PWM(atp),
		.AUDIO_TIMER_INVERTED_SECOND_PWM(atpb),
		.EXTERNAL_INTERRUPT_FOUR(external_interrupt_four), .SDI_IN(sdi),
		.UART_ZERO_RX_IN(rxi), .PORTA_IN(porta), .SLEEP(sleep),
		.WAKE(wake), .READBACK_ENABLED_FLAG(flag));
	pfsr_pin_model i_pins (.pin_out(pin_out), .pin_oe(pin_oe),
		.ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_in));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ***************************************
	// bus tasks and the port a pulse task
	// ***************************************
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		awaddr <= {24'h00_0000, a};
		wdata <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 40);
		if (n >= 40) failures++;
		an_b = analog_en;
		rs = bresp;
		bready <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		int n;
		@(posedge clk);
		araddr <= {24'h00_0000, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 40);
		if (n >= 40) failures++;
		rd = rdata[7:0];
		rs = rresp;
		rready <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		rdr(a);
		`CHK($sformatf("reg %h", a), e, rd)
	endtask
	task automatic pulse(input logic [7:0] v, input logic e);
		int seen;
		@(posedge clk);
		porta <= v;
		seen = 0;
		repeat (8) begin
			@(posedge clk);
			if (wake === 1'b1) seen++;
		end
		porta <= 8'hFF;
		repeat (8) @(posedge clk);
		`CHK("wake", e, seen != 0)
	endtask
	// ***************************************
	// scenarios
	// ***************************************
	task automatic t_reset();
		for (int i = 0; i < 8; i++) rchk(8'(4 * i), 8'h00);
		rchk(8'h24, pfsr_pkg::MASK_D);
		rchk(8'h28, pfsr_pkg::MASK_E);
		rchk(8'h2C, pfsr_pkg::MASK_F);
		rchk(8'h30, pfsr_pkg::MASK_G);
		for (int i = 0; i < 4; i++) rchk(8'(8'h34 + 4 * i), 8'hFF);
		`CHK("pin_oe", 24'h00_0000, pin_oe)
		`CHK("external_interrupt_four", 1'b1, external_interrupt_four)
	endtask
	task automatic t_select();
		for (int i = 6; i >= 0; i--) wr(8'(4 * i), 8'hFF);
		`CHK("analog_at_write", 24'h3F_FFFF, an_b)
		rchk(8'h00, 8'h3F);
		rchk(8'h0C, 8'hFF);
		rchk(8'h18, 8'h03);
		`CHK("analog", 24'h3F_FFFF, analog_en)
		`CHK("external_interrupt_four", 1'b0, external_interrupt_four)
		rchk(8'h28, 8'h00);
		rchk(8'h24, 8'h00);
		rchk(8'h30, 8'h18);
		wr(8'h1C, 8'hCA);
		`CHK("flag", 1'b1, flag)
		rchk(8'h20, 8'h01);
		rchk(8'h28, 8'hFF);
		wr(8'h1C, 8'hCB);
		rchk(8'h20, 8'h00);
		rchk(8'h2C, 8'h00);
		for (int i = 0; i < 7; i++) wr(8'(4 * i), 8'h00);
		wstrb <= 4'h0;
		wr(8'h04, 8'hFF);
		wstrb <= 4'hF;
		rchk(8'h04, 8'h00);
	endtask
	task automatic t_periph();
		tx <= 1'b0;
		pt0 <= 1'b1;
		wr(8'h00, 8'h12);
		rchk(8'h24, 8'h20);
		`CHK("pd6_out", 1'b1, pin_out[2])
		`CHK("pd4_out", 1'b0, pin_out[0])
		wr(8'h34, 8'h00);
		rchk(8'h24, 8'h70);
		wr(8'h1C, 8'hCA);
		rchk(8'h24, 8'h60);
		wr(8'h1C, 8'h00);
		wr(8'h34, 8'hFF);
		ext_en[1] <= 1'b1;
		wr(8'h00, 8'h04);
		repeat (3) @(posedge clk);
		`CHK("sdi", 1'b0, sdi)
		`CHK("rx", 1'b1, rxi)
		wr(8'h00, 8'h08);
		repeat (3) @(posedge clk);
		`CHK("rx", 1'b0, rxi)
		`CHK("sdi", 1'b1, sdi)
		txoe <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK("pd5_oe", 1'b1, pin_oe[1])
		txoe <= 1'b0;
		ext_en[1] <= 1'b0;
		wr(8'h00, 8'h00);
		atp <= 1'b1;
		wr(8'h14, 8'h40);
		wr(8'h18, 8'h01);
		repeat (2) @(posedge clk);
		`CHK("pg3_drive", 2'b11, {pin_oe[22], pin_out[22]})
		`CHK("pg4_drive", 2'b10, {pin_oe[23], pin_out[23]})
		wr(8'h14, 8'h00);
		wr(8'h18, 8'h00);
	endtask
	task automatic t_rmw();
		wr(8'h38, 8'h00);
		rchk(8'h28, 8'hFF);
		`CHK("pe_oe", 8'hFF, pin_oe[10:3])
		`CHK("pe_out", 8'hFF, pin_out[10:3])
		wr(8'h44, 8'h14);
		repeat (2) @(posedge clk);
		rchk(8'h28, 8'hFB);
		`CHK("pe2_out", 1'b0, pin_out[5])
		ext_en[11] <= 1'b1;
		repeat (3) @(posedge clk);
		wr(8'h44, 8'h2F);
		wr(8'h3C, 8'h00);
		ext_en[11] <= 1'b0;
		rchk(8'h2C, 8'hFE);
		`CHK("pf0_out", 1'b0, pin_out[11])
		wr(8'h44, 8'h53);
		rchk(8'h38, 8'h02);
	endtask
	task automatic t_wake();
		wr(8'h48, 8'h01);
		sleep <= 1'b1;
		pulse(8'hFE, 1'b1);
		pulse(8'hFD, 1'b0);
		sleep <= 1'b0;
		pulse(8'hFE, 1'b0);
	endtask
	task automatic t_err();
		rdr(8'h54);
		`CHK("rresp", pfsr_pkg::RESP_SLVERR, rs)
		wr(8'h50, 8'h01);
		`CHK("bresp", pfsr_pkg::RESP_SLVERR, rs)
		rchk(8'h44, 8'h00);
	endtask
	task automatic end_sim();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, sleep} = '0;
		{awaddr, wdata, araddr, ext_en, ext_val} = '0;
		wstrb = 4'hF;
		porta = 8'hFF;
		{tx, txoe, pt0, atp, atpb} = 5'b10000;
		failures = 0;
		checks = 0;
		rst = 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_select();
		t_periph();
		t_rmw();
		t_wake();
		t_err();
		end_sim();
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		end_sim();
	end
endmodule // tb_pin_function_select_readback
`default_nettype wire
